// ### logic/cac_map.svh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef CAC_MAP_SVH
`define CAC_MAP_SVH

// ==========================================
// register offsets (index on the register port)
`define CAC_OFS_MUX_SELECT 3'h0
`define CAC_OFS_CONV_CTRL_A 3'h1
`define CAC_OFS_CONV_CTRL_B 3'h2
`define CAC_OFS_CMP_CTRL 3'h3
`define CAC_OFS_CMP_DIGIN 3'h4
`define CAC_OFS_RESULT_LOW 3'h5
`define CAC_OFS_RESULT_HIGH 3'h6

// ==========================================
// mux_select_reg fields
`define CAC_MUX_REF_HI 7
`define CAC_MUX_REF_LO 6
`define CAC_MUX_LEFT_ADJ 5
`define CAC_MUX_CH_HI 2
`define CAC_MUX_CH_LO 0

// ==========================================
// converter_control_a fields
`define CAC_CA_ENABLE 7
`define CAC_CA_START 6
`define CAC_CA_AUTO 5
`define CAC_CA_DONE_FLAG 4
`define CAC_CA_DONE_IE 3

// ==========================================
// converter_control_b fields
`define CAC_CB_MUX_EN 6
`define CAC_CB_TRIG_HI 2
`define CAC_CB_TRIG_LO 0

// ==========================================
// comparator_control_status fields
`define CAC_CS_POWER_OFF 7
`define CAC_CS_BANDGAP 6
`define CAC_CS_SYNC_OUT 5
`define CAC_CS_IRQ_FLAG 4
`define CAC_CS_IRQ_EN 3
`define CAC_CS_CAPTURE 2
`define CAC_CS_MODE_HI 1
`define CAC_CS_MODE_LO 0

// ==========================================
// comparator_pin_input_disable fields
`define CAC_DI_NEG 1
`define CAC_DI_POS 0

// ==========================================
// reset values
`define CAC_RST_REG8 8'h00
`define CAC_RST_RESULT 10'h000

// ==========================================
// timing counts in converter clock cycles
`define CAC_CONV_NORMAL 5'h0D
`define CAC_CONV_FIRST 5'h19

// ==========================================
// trigger source code that means "conversion complete" (free running)
`define CAC_TRIG_FREE_RUN 3'h0

`endif

// ### logic/cac_pkg.sv
// types shared by the comparator and converter control
package cac_pkg;

	// ==========================================
	// comparator interrupt modes
	typedef enum logic [1:0] {
		CAC_MODE_TOGGLE = 2'h0,
		CAC_MODE_RESERVED = 2'h1,
		CAC_MODE_FALL = 2'h2,
		CAC_MODE_RISE = 2'h3
	} cac_cmp_mode_t;

	// ==========================================
	// conversion sequencer states, one-hot
	typedef enum logic [2:0] {
		CAC_SEQ_IDLE = 3'h1,
		CAC_SEQ_WAIT = 3'h2,
		CAC_SEQ_CONV = 3'h4
	} cac_seq_state_t;

endpackage : cac_pkg

// ### logic/cac_seq_if.sv
// signals between the control registers and the conversion sequencer
interface cac_seq_if;
	logic ce; // clock enable
	logic enable; // converter enable bit
	logic start; // one-cycle start request
	logic prescaler_reset; // trigger edge restarts the prescaler
	logic busy; // start pending or converting
	logic converting; // selections locked
	logic done; // one-cycle completion pulse
	logic sample; // one-cycle sample pulse to the analog core

	modport ctrl (
		output ce, enable, start, prescaler_reset,
		input busy, converting, done, sample
	);
	modport seq (
		input ce, enable, start, prescaler_reset,
		output busy, converting, done, sample
	);
endinterface : cac_seq_if

// ### logic/cac_conv_seq.sv
// converter prescaler and conversion cycle sequencer
`include "cac_map.svh"

module cac_conv_seq
	import cac_pkg::*;
#(
	parameter int PRESCALE_DIV = 4
) (
	input wire logic i_clock,
	input wire logic i_rst,
	cac_seq_if.seq sq
);

	localparam int PW = $clog2(PRESCALE_DIV + 1);
	localparam logic [PW-1:0] PRESC_LAST = PW'(PRESCALE_DIV - 1);

	// ==========================================
	// state
	cac_seq_state_t state; // sequencer state
	logic [PW-1:0] presc; // prescaler count
	logic [4:0] cyc; // converter cycles inside a conversion
	logic first_pending; // next conversion is the long first one
	logic first_run; // current conversion is a long one
	logic tick; // one converter clock edge
	logic last; // final converter cycle of a conversion

	assign tick = (presc == PRESC_LAST) && !sq.prescaler_reset;
	assign last = (state == CAC_SEQ_CONV) && tick &&
		(cyc == (first_run ? `CAC_CONV_FIRST : `CAC_CONV_NORMAL) - 5'h01);

	// ==========================================
	// prescaler: runs while enabled, held at zero otherwise
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			presc <= '0;
		end else if (sq.ce) begin
			if (!sq.enable || sq.prescaler_reset || tick) begin
				presc <= '0;
			end else begin
				presc <= presc + PW'(1);
			end
		end
	end

	// ==========================================
	// first conversion after enable is long
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			first_pending <= 1'b1;
		end else if (sq.ce) begin
			if (!sq.enable) begin
				first_pending <= 1'b1; // re-arm on switch off
			end else if (state == CAC_SEQ_WAIT && tick) begin
				first_pending <= 1'b0;
			end
		end
	end

	// ==========================================
	// conversion state machine
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state <= CAC_SEQ_IDLE;
			cyc <= 5'h00;
			first_run <= 1'b0;
		end else if (sq.ce) begin
			if (!sq.enable) begin
				state <= CAC_SEQ_IDLE; // abort on disable
				cyc <= 5'h00;
			end else begin
				unique case (state)
					CAC_SEQ_IDLE: begin
						if (sq.start) begin
							state <= CAC_SEQ_WAIT;
						end
					end
					CAC_SEQ_WAIT: begin
						if (tick) begin // begin on the next converter edge
							state <= CAC_SEQ_CONV;
							cyc <= 5'h00;
							first_run <= first_pending;
						end
					end
					CAC_SEQ_CONV: begin
						if (last) begin
							state <= sq.start ? CAC_SEQ_WAIT : CAC_SEQ_IDLE;
							cyc <= 5'h00;
						end else if (tick) begin
							cyc <= cyc + 5'h01;
						end
					end
				endcase
			end
		end
	end

	// ==========================================
	// status toward the control registers
	assign sq.done = last && sq.enable;
	assign sq.busy = (state != CAC_SEQ_IDLE);
	assign sq.converting = (state == CAC_SEQ_CONV);
	assign sq.sample = (state == CAC_SEQ_WAIT) && tick && sq.enable;

endmodule : cac_conv_seq

// ### logic/cac_top.sv
// comparator and converter control: registers, comparator events, conversion start and results
`include "cac_map.svh"

module cac_top
	import cac_pkg::*;
#(
	parameter int PRESCALE_DIV = 4
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_global_irq_enable,
	input wire logic i_cmp_irq_ack,
	input wire logic i_conv_irq_ack,
	output logic o_cmp_irq,
	output logic o_conv_irq,
	input wire logic i_cmp_raw,
	output logic o_cmp_power_off,
	output logic o_cmp_pos_bandgap,
	output logic o_cmp_neg_from_mux,
	output logic [2:0] o_cmp_neg_channel,
	output logic o_capture_input,
	input wire logic i_pos_pin_digital,
	input wire logic i_neg_pin_digital,
	output logic o_pos_pin_read,
	output logic o_neg_pin_read,
	output logic o_pos_digin_off,
	output logic o_neg_digin_off,
	input wire logic [7:0] i_trigger_src,
	output logic o_conv_enable,
	output logic [2:0] o_conv_channel,
	output logic [1:0] o_conv_reference,
	output logic o_conv_sample,
	input wire logic [9:0] i_conv_result
);

	// ==========================================
	// register fields
	logic [1:0] reference_select; // requested reference
	logic left_adjust; // result alignment
	logic [2:0] channel_select; // requested channel
	logic converter_enable; // converter on
	logic auto_trigger_enable; // auto-trigger mode
	logic conv_done_flag; // conversion complete flag
	logic conv_done_irq_enable; // conversion interrupt enable
	logic cmp_mux_enable; // negative input from channel mux
	logic [2:0] trigger_source_select; // auto-trigger source
	logic cmp_power_off; // comparator power off
	logic cmp_bandgap_select; // positive input from bandgap
	logic cmp_irq_flag; // comparator event flag
	logic cmp_irq_enable; // comparator interrupt enable
	logic cmp_capture_route; // comparator to capture input
	cac_cmp_mode_t cmp_irq_mode; // comparator event selection
	logic neg_pin_digin_off; // negative pin buffer off
	logic pos_pin_digin_off; // positive pin buffer off
	logic [9:0] result; // stored conversion result
	logic result_blocked; // updates held after a low-byte read

	// ==========================================
	// strobes and helpers
	logic wr_ca; // write to converter_control_a
	logic wr_cs; // write to comparator_control_status
	logic rd_low; // read of result_low_byte
	logic rd_high; // read of result_high_byte
	logic [2:0] cmp_sync; // comparator synchroniser chain
	logic cmp_sync_output; // accepted comparator level
	logic cmp_event; // selected comparator event
	logic [2:0] pin_sync_pos; // positive pin synchroniser
	logic [2:0] pin_sync_neg; // negative pin synchroniser
	logic trig_prev; // previous selected trigger level
	logic trig_level; // selected trigger level
	logic trig_edge; // rising edge of selected trigger
	logic sw_start; // software start request
	logic free_run; // done flag chosen as source
	logic auto_start; // auto-trigger start request
	logic [7:0] next_rdata; // read mux output

	cac_seq_if sq ();

	// decode one register address, for writes and reads
	function automatic logic hit(input logic [2:0] addr, input logic [2:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	assign wr_ca = i_wr && hit(i_addr, `CAC_OFS_CONV_CTRL_A);
	assign wr_cs = i_wr && hit(i_addr, `CAC_OFS_CMP_CTRL);
	assign rd_low = i_rd && hit(i_addr, `CAC_OFS_RESULT_LOW);
	assign rd_high = i_rd && hit(i_addr, `CAC_OFS_RESULT_HIGH);

	// ==========================================
	// sequencer
	assign sq.ce = i_ce;
	// next enable value, so a start written beside the enable bit is not lost
	assign sq.enable = (i_ce && wr_ca) ? i_wdata[`CAC_CA_ENABLE] : converter_enable;
	assign sw_start = wr_ca && i_wdata[`CAC_CA_START] && i_wdata[`CAC_CA_ENABLE];
	assign free_run = auto_trigger_enable && (trigger_source_select == `CAC_TRIG_FREE_RUN);
	assign trig_level = i_trigger_src[trigger_source_select];
	assign trig_edge = trig_level && !trig_prev;
	// a held-high trigger yields no new edge, so no restart
	assign auto_start = auto_trigger_enable && !free_run && trig_edge && !sq.busy;
	assign sq.prescaler_reset = auto_start;
	// software start taken when idle or on the last conversion cycle; free run restarts at done
	assign sq.start = sw_start || auto_start || (free_run && sq.done);

	cac_conv_seq #(
		.PRESCALE_DIV(PRESCALE_DIV)
	) u_seq (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.sq(sq)
	);

	// ==========================================
	// trigger edge history
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			trig_prev <= 1'b0;
		end else if (i_ce) begin
			trig_prev <= trig_level; // trigger flags cleared upstream re-arm the edge
		end
	end

	// ==========================================
	// mux_select_reg
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			reference_select <= 2'h0;
			left_adjust <= 1'b0;
			channel_select <= 3'h0;
		end else if (i_ce && i_wr && hit(i_addr, `CAC_OFS_MUX_SELECT)) begin
			reference_select <= i_wdata[`CAC_MUX_REF_HI:`CAC_MUX_REF_LO];
			left_adjust <= i_wdata[`CAC_MUX_LEFT_ADJ];
			channel_select <= i_wdata[`CAC_MUX_CH_HI:`CAC_MUX_CH_LO];
		end
	end

	// ==========================================
	// selections applied to the converter core
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_conv_channel <= 3'h0;
			o_conv_reference <= 2'h0;
		end else if (i_ce) begin
			// follow only while enabled; the sampling cycle already locks
			if (sq.enable && !sq.converting && !sq.sample) begin
				o_conv_channel <= channel_select;
				o_conv_reference <= reference_select;
			end
		end
	end

	// ==========================================
	// converter_control_a
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			converter_enable <= 1'b0;
			auto_trigger_enable <= 1'b0;
			conv_done_irq_enable <= 1'b0;
		end else if (i_ce && wr_ca) begin
			converter_enable <= i_wdata[`CAC_CA_ENABLE];
			auto_trigger_enable <= i_wdata[`CAC_CA_AUTO];
			conv_done_irq_enable <= i_wdata[`CAC_CA_DONE_IE];
		end
	end

	// ==========================================
	// conversion complete flag: set wins over clear
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			conv_done_flag <= 1'b0;
		end else if (i_ce) begin
			if (sq.done) begin
				conv_done_flag <= 1'b1;
			end else if (i_conv_irq_ack || (wr_ca && i_wdata[`CAC_CA_DONE_FLAG])) begin
				conv_done_flag <= 1'b0;
			end
		end
	end

	// ==========================================
	// result store and read interlock
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			result <= `CAC_RST_RESULT;
		end else if (i_ce && sq.done && !result_blocked) begin
			result <= i_conv_result;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			result_blocked <= 1'b0;
		end else if (i_ce) begin
			if (rd_high) begin
				result_blocked <= 1'b0;
			end else if (rd_low) begin
				result_blocked <= 1'b1;
			end
		end
	end

	// ==========================================
	// converter_control_b
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			cmp_mux_enable <= 1'b0;
			trigger_source_select <= 3'h0;
		end else if (i_ce && i_wr && hit(i_addr, `CAC_OFS_CONV_CTRL_B)) begin
			cmp_mux_enable <= i_wdata[`CAC_CB_MUX_EN];
			trigger_source_select <= i_wdata[`CAC_CB_TRIG_HI:`CAC_CB_TRIG_LO];
		end
	end

	// ==========================================
	// comparator_control_status writable bits
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			cmp_power_off <= 1'b0;
			cmp_bandgap_select <= 1'b0;
			cmp_irq_enable <= 1'b0;
			cmp_capture_route <= 1'b0;
			cmp_irq_mode <= CAC_MODE_TOGGLE;
		end else if (i_ce && wr_cs) begin
			cmp_power_off <= i_wdata[`CAC_CS_POWER_OFF];
			cmp_bandgap_select <= i_wdata[`CAC_CS_BANDGAP];
			cmp_irq_enable <= i_wdata[`CAC_CS_IRQ_EN];
			cmp_capture_route <= i_wdata[`CAC_CS_CAPTURE];
			// mode changes may raise an event; software masks first
			cmp_irq_mode <= cac_cmp_mode_t'(i_wdata[`CAC_CS_MODE_HI:`CAC_CS_MODE_LO]);
		end
	end

	// ==========================================
	// comparator synchroniser: accept a level once stages 2 and 3 agree
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			cmp_sync <= 3'h0;
			cmp_sync_output <= 1'b0;
		end else if (i_ce) begin
			cmp_sync <= {cmp_sync[1:0], i_cmp_raw};
			if (cmp_sync[1] == cmp_sync[2]) begin
				cmp_sync_output <= cmp_sync[2];
			end
		end
	end

	// ==========================================
	// comparator event selection
	always_comb begin
		logic changed;
		changed = 1'b0;
		changed = (cmp_sync[1] == cmp_sync[2]) && (cmp_sync[2] != cmp_sync_output);
		unique case (cmp_irq_mode)
			CAC_MODE_TOGGLE: cmp_event = changed;
			CAC_MODE_FALL: cmp_event = changed && !cmp_sync[2];
			CAC_MODE_RISE: cmp_event = changed && cmp_sync[2];
			CAC_MODE_RESERVED: cmp_event = 1'b0;
		endcase
	end

	// ==========================================
	// comparator flag: set wins over ack and write-one clear
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			cmp_irq_flag <= 1'b0;
		end else if (i_ce) begin
			if (cmp_event) begin
				cmp_irq_flag <= 1'b1;
			end else if (i_cmp_irq_ack || (wr_cs && i_wdata[`CAC_CS_IRQ_FLAG])) begin
				cmp_irq_flag <= 1'b0;
			end
		end
	end

	// ==========================================
	// comparator_pin_input_disable and pin reads
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			neg_pin_digin_off <= 1'b0;
			pos_pin_digin_off <= 1'b0;
		end else if (i_ce && i_wr && hit(i_addr, `CAC_OFS_CMP_DIGIN)) begin
			neg_pin_digin_off <= i_wdata[`CAC_DI_NEG];
			pos_pin_digin_off <= i_wdata[`CAC_DI_POS];
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			pin_sync_pos <= 3'h0;
			pin_sync_neg <= 3'h0;
			o_pos_pin_read <= 1'b0;
			o_neg_pin_read <= 1'b0;
		end else if (i_ce) begin
			pin_sync_pos <= {pin_sync_pos[1:0], i_pos_pin_digital};
			pin_sync_neg <= {pin_sync_neg[1:0], i_neg_pin_digital};
			if (pos_pin_digin_off) begin
				o_pos_pin_read <= 1'b0;
			end else if (pin_sync_pos[1] == pin_sync_pos[2]) begin
				o_pos_pin_read <= pin_sync_pos[2];
			end
			if (neg_pin_digin_off) begin
				o_neg_pin_read <= 1'b0;
			end else if (pin_sync_neg[1] == pin_sync_neg[2]) begin
				o_neg_pin_read <= pin_sync_neg[2];
			end
		end
	end

	// ==========================================
	// analog steering outputs
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_cmp_power_off <= 1'b0;
			o_cmp_pos_bandgap <= 1'b0;
			o_cmp_neg_from_mux <= 1'b0;
			o_cmp_neg_channel <= 3'h0;
			o_pos_digin_off <= 1'b0;
			o_neg_digin_off <= 1'b0;
			o_capture_input <= 1'b0;
		end else if (i_ce) begin
			o_cmp_power_off <= cmp_power_off;
			o_cmp_pos_bandgap <= cmp_bandgap_select;
			o_cmp_neg_from_mux <= cmp_mux_enable && !converter_enable;
			o_cmp_neg_channel <= channel_select;
			o_pos_digin_off <= pos_pin_digin_off;
			o_neg_digin_off <= neg_pin_digin_off;
			o_capture_input <= cmp_capture_route && cmp_sync_output;
		end
	end

	assign o_conv_enable = converter_enable;
	assign o_conv_sample = sq.sample;
	assign o_cmp_irq = cmp_irq_flag && cmp_irq_enable && i_global_irq_enable;
	assign o_conv_irq = conv_done_flag && conv_done_irq_enable && i_global_irq_enable;

	// ==========================================
	// read mux
	always_comb begin
		next_rdata = 8'h00;
		unique case (i_addr)
			`CAC_OFS_MUX_SELECT: next_rdata = {reference_select, left_adjust, 2'h0,
				channel_select};
			`CAC_OFS_CONV_CTRL_A: next_rdata = {converter_enable, sq.busy,
				auto_trigger_enable, conv_done_flag, conv_done_irq_enable, 3'h0};
			`CAC_OFS_CONV_CTRL_B: next_rdata = {1'b0, cmp_mux_enable, 3'h0,
				trigger_source_select};
			`CAC_OFS_CMP_CTRL: next_rdata = {cmp_power_off, cmp_bandgap_select,
				cmp_sync_output, cmp_irq_flag, cmp_irq_enable, cmp_capture_route,
				cmp_irq_mode};
			`CAC_OFS_CMP_DIGIN: next_rdata = {6'h00, neg_pin_digin_off, pos_pin_digin_off};
			`CAC_OFS_RESULT_LOW: next_rdata = left_adjust ? {result[1:0], 6'h00} :
				result[7:0];
			`CAC_OFS_RESULT_HIGH: next_rdata = left_adjust ? result[9:2] :
				{6'h00, result[9:8]};
			default: next_rdata = 8'h00; // unmapped
		endcase
	end

	// read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_rdata <= `CAC_RST_REG8;
		end else if (i_ce) begin
			o_rdata <= i_rd ? next_rdata : 8'h00;
		end
	end

endmodule : cac_top

// ### verif/cac_core_model.sv
// behavioural analog comparator and converter core
module cac_core_model (
	input wire logic i_clock,
	input wire logic i_sample,
	input wire logic [2:0] i_channel,
	input wire logic i_power_off,
	input wire logic i_level,
	output logic o_raw,
	output logic [9:0] o_result
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// unpowered comparator rests low
	assign o_raw = i_power_off ? 1'b0 : i_level;
	// result encodes the channel held at sampling
	always_ff @(posedge i_clock) begin
		if (i_sample) begin
			o_result <= {i_channel, 7'h35};
		end
	end
endmodule : cac_core_model

// ### verif/cac_top_sva.sv
// port assertions of the comparator and converter control
module cac_top_sva
	import cac_pkg::*;
#(
	parameter int PRESCALE_DIV = 4
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_global_irq_enable,
	input wire logic o_cmp_irq,
	input wire logic o_cmp_neg_from_mux,
	input wire logic o_conv_enable,
	input wire logic o_pos_digin_off,
	input wire logic o_neg_digin_off,
	input wire logic o_pos_pin_read,
	input wire logic o_neg_pin_read,
	input wire logic o_conv_sample,
	input wire logic [2:0] o_conv_channel
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// ==========================================
	// assertions
	AST_NEG_MUX: assert property (o_cmp_neg_from_mux |-> !$past(o_conv_enable))
		else $error("negative input from mux while converter on");
	AST_CMP_IRQ: assert property (o_cmp_irq |-> i_global_irq_enable)
		else $error("comparator irq without global enable");
	AST_POS_PIN: assert property (o_pos_digin_off && $past(o_pos_digin_off) |-> !o_pos_pin_read)
		else $error("positive pin read not forced low");
	AST_NEG_PIN: assert property (o_neg_digin_off && $past(o_neg_digin_off) |-> !o_neg_pin_read)
		else $error("negative pin read not forced low");
	AST_SAMPLE_OFF: assert property (!o_conv_enable |-> !o_conv_sample)
		else $error("sample while converter disabled");
	AST_CH_LOCK: assert property (o_conv_sample |=> $stable(o_conv_channel)[*8])
		else $error("channel moved during conversion");
	AST_CH_HOLD: assert property (!o_conv_enable && !$past(o_conv_enable) |-> $stable(o_conv_channel))
		else $error("channel applied while converter disabled");
	AST_SAMPLE_GAP: assert property (o_conv_sample |=> !o_conv_sample[*8])
		else $error("conversion shorter than allowed");
	// main scenarios reached
	COV_SAMPLE: cover property (o_conv_sample);
	COV_CMP_IRQ: cover property (o_cmp_irq);
	COV_NEG_MUX: cover property (o_cmp_neg_from_mux);
endmodule : cac_top_sva

bind cac_top cac_top_sva #(.PRESCALE_DIV(PRESCALE_DIV)) u_cac_top_sva (.i_clock, .i_rst,
	.i_global_irq_enable, .o_cmp_irq, .o_cmp_neg_from_mux, .o_conv_enable, .o_pos_digin_off,
	.o_neg_digin_off, .o_pos_pin_read, .o_neg_pin_read, .o_conv_sample, .o_conv_channel);

// ### verif/cac_top_bench.sv
// self-checking bench for the comparator and converter control
module cac_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] trig = 8'h00;
	logic level = 1'b0;
	logic pin = 1'b1;
	logic gie = 1'b1;
	logic ack = 1'b0;
	logic [7:0] o_rdata;
	logic cmp_irq, conv_irq, pwr_off, bg, cap, sample, raw, pos_rd, neg_rd, neg_mux, got, fl;
	logic [2:0] neg_ch, conv_ch;
	logic [9:0] result;
	int bad_count = 0;
	int total_checks = 0;
	// ==========================================
	// clock, design and core model
	always #12.5 i_clock = ~i_clock;
	cac_top #(.PRESCALE_DIV(2)) u_cac_top (.i_clock, .i_rst, .i_ce(1'b1), .i_addr, .i_wdata,
		.i_wr, .i_rd, .o_rdata, .i_global_irq_enable(gie), .i_cmp_irq_ack(ack),
		.i_conv_irq_ack(1'b0), .o_cmp_irq(cmp_irq), .o_conv_irq(conv_irq), .i_cmp_raw(raw),
		.o_cmp_power_off(pwr_off), .o_cmp_pos_bandgap(bg), .o_cmp_neg_from_mux(neg_mux),
		.o_cmp_neg_channel(neg_ch), .o_capture_input(cap), .i_pos_pin_digital(pin),
		.i_neg_pin_digital(pin), .o_pos_pin_read(pos_rd), .o_neg_pin_read(neg_rd),
		.o_pos_digin_off(), .o_neg_digin_off(), .i_trigger_src(trig), .o_conv_enable(),
		.o_conv_channel(conv_ch), .o_conv_reference(), .o_conv_sample(sample),
		.i_conv_result(result));
	cac_core_model u_cac_core_model (.i_clock, .i_sample(sample), .i_channel(conv_ch),
		.i_power_off(pwr_off), .i_level(level), .o_raw(raw), .o_result(result));
	// ==========================================
	// compare, bus and wait tasks
	task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] act);
		total_checks++;
		if (act !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, act);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		chk("rdata", {2'h0, e}, {2'h0, o_rdata});
	endtask : rd
	task automatic wait_irq(input logic want);
		got = 1'b0;
		for (int n = 0; n < 150 && !got; n++) begin
			@(posedge i_clock);
			#1;
			got = (conv_irq === 1'b1);
		end
		chk("conv_irq", {9'h0, want}, {9'h0, got});
		if (want && !got) close_out();
	endtask : wait_irq
	task automatic close_out();
		if (bad_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out
	// ==========================================
	// main sequence
	initial begin
		repeat (5) @(posedge i_clock);
		i_rst <= 1'b0;
		for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
		chk("pos_read", 10'h001, {9'h0, pos_rd});
		wr(3'h4, 8'h03);
		@(posedge i_clock);
		#1;
		chk("pin_reads", 10'h000, {8'h0, pos_rd, neg_rd});
		// every interrupt mode against a rise then a fall
		for (int m = 0; m < 4; m++) begin
			wr(3'h3, 8'h10 | 8'(m));
			wr(3'h3, 8'h08 | 8'(m));
			level <= 1'b1;
			repeat (6) @(posedge i_clock);
			fl = (m == 0 || m == 3);
			rd(3'h3, {2'h0, 1'b1, fl, 2'h2, 2'(m)});
			@(posedge i_clock);
			level <= 1'b0;
			repeat (6) @(posedge i_clock);
			fl = fl | (m == 0 || m == 2);
			rd(3'h3, {3'h0, fl, 2'h2, 2'(m)});
			chk("cmp_irq", {9'h0, fl}, {9'h0, cmp_irq});
		end
		// global enable masks the request, vector taken clears the flag
		@(posedge i_clock);
		gie <= 1'b0;
		#1;
		chk("cmp_irq_gie", 10'h000, {9'h0, cmp_irq});
		@(posedge i_clock);
		gie <= 1'b1;
		ack <= 1'b1;
		@(posedge i_clock);
		ack <= 1'b0;
		level <= 1'b1;
		#1;
		chk("cmp_ack", 10'h000, {9'h0, cmp_irq});
		wr(3'h3, 8'h44);
		repeat (7) @(posedge i_clock);
		#1;
		chk("bandgap_capture", 10'h003, {8'h0, bg, cap});
		wr(3'h3, 8'h84);
		repeat (7) @(posedge i_clock);
		#1;
		chk("off_capture", 10'h002, {8'h0, pwr_off, cap});
		// negative input from the channel mux
		wr(3'h2, 8'h40);
		wr(3'h0, 8'h05);
		@(posedge i_clock);
		#1;
		chk("neg_mux", 10'h00D, {6'h0, neg_mux, neg_ch});
		// first conversion, channel moved while busy
		wr(3'h1, 8'hC8);
		rd(3'h1, 8'hC8);
		wr(3'h0, 8'h02);
		chk("neg_pin", 10'h000, {9'h0, neg_mux});
		wait_irq(1'b1);
		rd(3'h1, 8'h98);
		rd(3'h5, 8'hB5);
		// result lost while the low byte holds the registers
		wr(3'h1, 8'hD8);
		wait_irq(1'b1);
		rd(3'h6, 8'h02);
		rd(3'h5, 8'hB5);
		rd(3'h6, 8'h02);
		wr(3'h0, 8'h22);
		wr(3'h1, 8'hD8);
		wait_irq(1'b1);
		rd(3'h5, 8'h40);
		rd(3'h6, 8'h4D);
		// auto trigger on source 1, held level, then a software start
		wr(3'h2, 8'h01);
		wr(3'h1, 8'hB8);
		trig <= 8'h02;
		wait_irq(1'b1);
		wr(3'h1, 8'hB8);
		wait_irq(1'b0);
		wr(3'h1, 8'hF8);
		wait_irq(1'b1);
		// trigger dropped and raised again gives a fresh edge
		wr(3'h1, 8'hB8);
		trig <= 8'h00;
		@(posedge i_clock);
		trig <= 8'h02;
		wait_irq(1'b1);
		// done flag as source keeps converting without a clear
		wr(3'h2, 8'h00);
		wr(3'h1, 8'hF8);
		wait_irq(1'b1);
		rd(3'h1, 8'hF8);
		wr(3'h1, 8'hB8);
		wait_irq(1'b1);
		close_out();
	end
endmodule : cac_top_bench
